// File: hdl/vectored_request_unit.v
// vectored request unit: sorts 19 request channels into fast, vectored
// and non-vectored classes and presents request lines, vector and status.
// assumes peripheral flags and settings are on sys_clk; external request
// pins are asynchronous; settings come from plain input ports.
`timescale 1ns/1ps
`include "request_unit_consts.vh"
module vectored_request_unit
#(
    parameter CHANNELS = `CHANNEL_COUNT,
    parameter SLOTS = `SLOT_COUNT,
    parameter IDX_W = `CHANNEL_INDEX_WIDTH,
    parameter ADDR_W = `ADDRESS_WIDTH
)
(
    input wire sys_clk,
    input wire rst,
    input wire watchdog_request,
    input wire software_request,
    input wire debug_channel_receive,
    input wire debug_channel_transmit,
    input wire [`TIMER_MATCH_COUNT-1:0] timer_a_match,
    input wire [`TIMER_MATCH_COUNT-1:0] timer_b_match,
    input wire serial_a_line_status_flag,
    input wire serial_a_transmit_holding_empty,
    input wire serial_a_receive_data_available,
    input wire serial_a_character_timeout_flag,
    input wire serial_b_line_status_flag,
    input wire serial_b_transmit_holding_empty,
    input wire serial_b_receive_data_available,
    input wire serial_b_character_timeout_flag,
    input wire serial_b_modem_status_flag,
    input wire [`PULSE_MATCH_COUNT-1:0] pulse_width_match,
    input wire two_wire_state_change,
    input wire periph_a_serial_transfer_done,
    input wire periph_a_serial_mode_fault,
    input wire periph_b_serial_transfer_done,
    input wire periph_b_serial_mode_fault,
    input wire sync_transmit_raw,
    input wire sync_receive_raw,
    input wire sync_timeout_raw,
    input wire sync_overrun_raw,
    input wire multiplier_locked,
    input wire clock_increment_flag,
    input wire clock_alarm_flag,
    input wire [`EXTERNAL_COUNT-1:0] external_request_pin,
    input wire converter_done,
    input wire [CHANNELS-1:0] channel_enable,
    input wire [CHANNELS-1:0] fast_select,
    input wire [SLOTS-1:0] slot_enable,
    input wire [SLOTS*IDX_W-1:0] slot_channel,
    input wire [SLOTS*ADDR_W-1:0] slot_address,
    input wire [ADDR_W-1:0] default_address,
    output reg fast_request_q,
    output reg normal_request_q,
    output reg [ADDR_W-1:0] vector_address_q,
    output reg [CHANNELS-1:0] fast_status_q,
    output reg [CHANNELS-1:0] normal_status_q,
    output reg [CHANNELS-1:0] raw_status_q
);
    localparam PAD_W = (1 << IDX_W) - CHANNELS;
    wire [`EXTERNAL_COUNT-1:0] external_level;
    // per peripheral request lines
    wire watchdog_line;
    wire software_line;
    wire debug_receive_line;
    wire debug_transmit_line;
    wire timer_a_line;
    wire timer_b_line;
    wire serial_a_line;
    wire serial_b_line;
    wire pulse_width_line;
    wire two_wire_line;
    wire periph_a_line;
    wire periph_b_line;
    wire multiplier_line;
    wire real_time_line;
    wire converter_line;
    wire [(1 << IDX_W)-1:0] normal_wide;
    wire [SLOTS:0] slot_taken;
    wire [SLOTS-1:0] slot_hit;
    wire [(SLOTS+1)*ADDR_W-1:0] slot_pick;
    reg [CHANNELS-1:0] raw_d;
    reg [CHANNELS-1:0] fast_d;
    reg [CHANNELS-1:0] normal_d;
    reg [ADDR_W-1:0] vector_d;
    integer n;
    integer m;
    genvar g;

    // external pins cross into the clock domain
    pin_sync_filter
    #(
        .WIDTH(`EXTERNAL_COUNT)
    )
    external_sync
    (
        .sys_clk(sys_clk),
        .rst(rst),
        .pin_in(external_request_pin),
        .level_q(external_level)
    );

    // one line per peripheral, the OR of its flags
    assign watchdog_line = watchdog_request;
    assign software_line = software_request;
    assign debug_receive_line = debug_channel_receive;
    assign debug_transmit_line = debug_channel_transmit;
    assign timer_a_line = |timer_a_match;
    assign timer_b_line = |timer_b_match;
    assign serial_a_line = serial_a_line_status_flag
        | serial_a_transmit_holding_empty
        | serial_a_receive_data_available
        | serial_a_character_timeout_flag;
    assign serial_b_line = serial_b_line_status_flag
        | serial_b_transmit_holding_empty
        | serial_b_receive_data_available
        | serial_b_character_timeout_flag
        | serial_b_modem_status_flag;
    assign pulse_width_line = |pulse_width_match;
    assign two_wire_line = two_wire_state_change;
    assign periph_a_line = periph_a_serial_transfer_done
        | periph_a_serial_mode_fault;
    assign periph_b_line = periph_b_serial_transfer_done
        | periph_b_serial_mode_fault
        | sync_transmit_raw
        | sync_receive_raw
        | sync_timeout_raw
        | sync_overrun_raw;
    assign multiplier_line = multiplier_locked;
    assign real_time_line = clock_increment_flag
        | clock_alarm_flag;
    assign converter_line = converter_done;

    // channel vector in channel order
    always @*
    begin
        raw_d = {CHANNELS{1'b0}};
        raw_d[`CH_WATCHDOG] = watchdog_line;
        raw_d[`CH_SOFTWARE] = software_line;
        raw_d[`CH_DEBUG_RECEIVE] = debug_receive_line;
        raw_d[`CH_DEBUG_TRANSMIT] = debug_transmit_line;
        raw_d[`CH_TIMER_A] = timer_a_line;
        raw_d[`CH_TIMER_B] = timer_b_line;
        raw_d[`CH_SERIAL_A] = serial_a_line;
        raw_d[`CH_SERIAL_B] = serial_b_line;
        raw_d[`CH_PULSE_WIDTH] = pulse_width_line;
        raw_d[`CH_TWO_WIRE] = two_wire_line;
        raw_d[`CH_PERIPH_SERIAL_A] = periph_a_line;
        raw_d[`CH_PERIPH_SERIAL_B] = periph_b_line;
        raw_d[`CH_MULTIPLIER] = multiplier_line;
        raw_d[`CH_REAL_TIME] = real_time_line;
        for (n = 0; n < `EXTERNAL_COUNT; n = n + 1)
        begin
            raw_d[`CH_EXTERNAL_FIRST + n] = external_level[n];
        end
        raw_d[`CH_CONVERTER] = converter_line;
    end

    // class sorting; a disabled channel joins neither class
    always @*
    begin
        fast_d = {CHANNELS{1'b0}};
        normal_d = {CHANNELS{1'b0}};
        for (m = 0; m < CHANNELS; m = m + 1)
        begin
            if (channel_enable[m] && fast_select[m])
            begin
                fast_d[m] = raw_d[m];
            end
            else if (channel_enable[m])
            begin
                normal_d[m] = raw_d[m];
            end
        end
    end

    // padded so any slot channel code indexes in range and codes above match nothing
    assign normal_wide = {{PAD_W{1'b0}}, normal_d};
    assign slot_taken[0] = 1'b0;
    assign slot_pick[ADDR_W-1:0] = {ADDR_W{1'b0}};

    // per slot match; a matching lower slot blocks every slot above it
    generate
        for (g = 0; g < SLOTS; g = g + 1)
        begin : slot_stage
            wire [IDX_W-1:0] code;
            wire is_first;
            assign code = slot_channel[g*IDX_W +: IDX_W];
            assign slot_hit[g] = slot_enable[g] & normal_wide[code];
            assign is_first = slot_hit[g] & ~slot_taken[g];
            assign slot_taken[g+1] = slot_taken[g] | slot_hit[g];
            assign slot_pick[(g+1)*ADDR_W +: ADDR_W] = slot_pick[g*ADDR_W +: ADDR_W]
                | ({ADDR_W{is_first}} & slot_address[g*ADDR_W +: ADDR_W]);
        end
    endgenerate

    // winning slot address, else the shared default
    always @*
    begin
        if (slot_taken[SLOTS])
        begin
            vector_d = slot_pick[SLOTS*ADDR_W +: ADDR_W];
        end
        else
        begin
            vector_d = default_address;
        end
    end

    // fast request line
    always @(posedge sys_clk)
    begin
        if (rst)
        begin
            fast_request_q <= 1'b0;
        end
        else
        begin
            fast_request_q <= |fast_d;
        end
    end

    // normal request line
    always @(posedge sys_clk)
    begin
        if (rst)
        begin
            normal_request_q <= 1'b0;
        end
        else
        begin
            normal_request_q <= |normal_d;
        end
    end

    // vector address
    always @(posedge sys_clk)
    begin
        if (rst)
        begin
            vector_address_q <= `RESET_ADDRESS;
        end
        else
        begin
            vector_address_q <= vector_d;
        end
    end

    // fast status word
    always @(posedge sys_clk)
    begin
        if (rst)
        begin
            fast_status_q <= `RESET_STATUS;
        end
        else
        begin
            fast_status_q <= fast_d;
        end
    end

    // normal status word
    always @(posedge sys_clk)
    begin
        if (rst)
        begin
            normal_status_q <= `RESET_STATUS;
        end
        else
        begin
            normal_status_q <= normal_d;
        end
    end

    // raw channel lines
    always @(posedge sys_clk)
    begin
        if (rst)
        begin
            raw_status_q <= `RESET_STATUS;
        end
        else
        begin
            raw_status_q <= raw_d;
        end
    end
endmodule

// File: hdl/request_unit_consts.vh
// constants for the vectored request unit
// assumes inclusion by bare name from design files under hdl/
`ifndef REQUEST_UNIT_CONSTS_VH
`define REQUEST_UNIT_CONSTS_VH

`define CHANNEL_COUNT 19
`define SLOT_COUNT 16
`define CHANNEL_INDEX_WIDTH 5
`define ADDRESS_WIDTH 32

`define CH_WATCHDOG 0
`define CH_SOFTWARE 1
`define CH_DEBUG_RECEIVE 2
`define CH_DEBUG_TRANSMIT 3
`define CH_TIMER_A 4
`define CH_TIMER_B 5
`define CH_SERIAL_A 6
`define CH_SERIAL_B 7
`define CH_PULSE_WIDTH 8
`define CH_TWO_WIRE 9
`define CH_PERIPH_SERIAL_A 10
`define CH_PERIPH_SERIAL_B 11
`define CH_MULTIPLIER 12
`define CH_REAL_TIME 13
`define CH_EXTERNAL_FIRST 14
`define CH_CONVERTER 18

`define EXTERNAL_COUNT 4
`define TIMER_MATCH_COUNT 4
`define PULSE_MATCH_COUNT 7

`define RESET_ADDRESS 32'h00000000
`define RESET_STATUS 19'h00000

`endif

// File: hdl/pin_sync_filter.v
// three-stage pin synchroniser with agreement filter
// assumes asynchronous pin levels and a synchronous active-high reset
`timescale 1ns/1ps
module pin_sync_filter
#(
    parameter WIDTH = 4
)
(
    input wire sys_clk,
    input wire rst,
    input wire [WIDTH-1:0] pin_in,
    output reg [WIDTH-1:0] level_q
);
    reg [WIDTH-1:0] stage1_q;
    reg [WIDTH-1:0] stage2_q;
    reg [WIDTH-1:0] stage3_q;
    integer k;

    always @(posedge sys_clk)
    begin
        if (rst)
        begin
            stage1_q <= {WIDTH{1'b0}};
            stage2_q <= {WIDTH{1'b0}};
            stage3_q <= {WIDTH{1'b0}};
            level_q <= {WIDTH{1'b0}};
        end
        else
        begin
            stage1_q <= pin_in;
            stage2_q <= stage1_q;
            stage3_q <= stage2_q;
            // accept a change once stages two and three agree
            for (k = 0; k < WIDTH; k = k + 1)
            begin
                if (stage2_q[k] == stage3_q[k])
                begin
                    level_q[k] <= stage3_q[k];
                end
            end
        end
    end
endmodule

// File: testbench/req_monitor.sv
// checker of request unit outputs against its settings
// assumes binding onto the vectored_request_unit ports
`timescale 1ns/1ps
module req_monitor
(
    input wire sys_clk,
    input wire rst,
    input wire [18:0] channel_enable,
    input wire [18:0] fast_select,
    input wire [31:0] default_address,
    input wire fast_request_q,
    input wire normal_request_q,
    input wire [31:0] vector_address_q,
    input wire [18:0] fast_status_q,
    input wire [18:0] normal_status_q,
    input wire [18:0] raw_status_q
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    fast_merge_a: assert property (fast_request_q == |fast_status_q)
        else $error("fast merge");
    normal_merge_a: assert property (normal_request_q == |normal_status_q)
        else $error("normal merge");
    class_split_a: assert property ((fast_status_q & normal_status_q) == 0)
        else $error("class overlap");
    fast_word_a: assert property (fast_status_q ==
        (raw_status_q & $past(channel_enable & fast_select))) else $error("fast word");
    normal_word_a: assert property (normal_status_q ==
        (raw_status_q & $past(channel_enable & ~fast_select))) else $error("normal word");
    vector_default_a: assert property (!$past(rst) && normal_status_q == 0 |->
        vector_address_q == $past(default_address)) else $error("vector default");
    fast_gate_a: assert property (fast_request_q |->
        $past(|(channel_enable & fast_select))) else $error("fast gate");
    idle_rest_a: assert property ($rose(raw_status_q == 0) |->
        !fast_request_q && !normal_request_q) else $error("idle rest");
endmodule
bind vectored_request_unit req_monitor mon (.*);

// File: testbench/core_model.sv
// core side: takes fast over normal, latches the handler to run
// assumes request unit outputs on sys_clk
`timescale 1ns/1ps
module core_model
(
    input wire sys_clk,
    input wire fast_request_q,
    input wire normal_request_q,
    input wire [31:0] vector_address_q,
    output reg [31:0] handler_q
);
    always @(posedge sys_clk)
    begin
        handler_q <= fast_request_q ? 32'hFFFFFFFF : normal_request_q ? vector_address_q : 32'h0;
    end
endmodule

// File: testbench/vectored_request_unit_tb_top.sv
// bench for the vectored request unit: map, priority, class, mask
// assumes req_monitor and core_model compiled before it
`timescale 1ns/1ps
module vectored_request_unit_tb_top;
    logic sys_clk = 0, rst = 1, fr, nr;
    logic [44:0] f = 0;
    logic [18:0] en = 0, fs = 0, rs, fst, nst;
    logic [15:0] se = 0;
    logic [79:0] sc = 0;
    logic [511:0] sa = 0;
    logic [31:0] da = 32'h0000D000, va, hq;
    int bad_count = 0, total_checks = 0;
    vectored_request_unit DUT (.sys_clk, .rst, .watchdog_request(f[0]),
        .software_request(f[1]), .debug_channel_receive(f[2]), .debug_channel_transmit(f[3]),
        .timer_a_match(f[7:4]), .timer_b_match(f[11:8]), .serial_a_line_status_flag(f[12]),
        .serial_a_transmit_holding_empty(f[13]), .serial_a_receive_data_available(f[14]),
        .serial_a_character_timeout_flag(f[15]), .serial_b_line_status_flag(f[16]),
        .serial_b_transmit_holding_empty(f[17]), .serial_b_receive_data_available(f[18]),
        .serial_b_character_timeout_flag(f[19]), .serial_b_modem_status_flag(f[20]),
        .pulse_width_match(f[27:21]), .two_wire_state_change(f[28]),
        .periph_a_serial_transfer_done(f[29]), .periph_a_serial_mode_fault(f[30]),
        .periph_b_serial_transfer_done(f[31]), .periph_b_serial_mode_fault(f[32]),
        .sync_transmit_raw(f[33]), .sync_receive_raw(f[34]), .sync_timeout_raw(f[35]),
        .sync_overrun_raw(f[36]), .multiplier_locked(f[37]), .clock_increment_flag(f[38]),
        .clock_alarm_flag(f[39]), .external_request_pin(f[43:40]), .converter_done(f[44]),
        .channel_enable(en), .fast_select(fs), .slot_enable(se), .slot_channel(sc),
        .slot_address(sa), .default_address(da), .fast_request_q(fr), .normal_request_q(nr),
        .vector_address_q(va), .fast_status_q(fst), .normal_status_q(nst), .raw_status_q(rs));
    core_model core (.sys_clk, .fast_request_q(fr), .normal_request_q(nr),
        .vector_address_q(va), .handler_q(hq));
    initial forever #25 sys_clk = ~sys_clk;
    task close_out;
        if (bad_count == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial
    begin
        #100000;
        bad_count++;
        close_out;
    end
    task chk(input logic [63:0] s, e);
        total_checks++;
        if (s !== e)
        begin
            bad_count++;
            $display("unexpected at %0t: %h vs %h", $time, s, e);
        end
    endtask
    task w(int n);
        repeat (n) @(posedge sys_clk);
        #5;
    endtask
    // flag bit to channel number
    function int ch(int i);
        if (i < 4) return i;
        if (i < 21) return i < 8 ? 4 : i < 12 ? 5 : i < 16 ? 6 : 7;
        if (i < 29) return i < 28 ? 8 : 9;
        if (i < 40) return i < 31 ? 10 : i < 37 ? 11 : i < 38 ? 12 : 13;
        return i < 44 ? i - 26 : 18;
    endfunction
    task t_map;
        for (int i = 0; i < 45; i++)
        begin
            @(posedge sys_clk);
            en <= '1;
            f <= 45'h1 << i;
            w(6);
            chk(rs, 32'h1 << ch(i));
            chk(nst, 32'h1 << ch(i));
            chk(nr, 1);
            chk(va, da);
        end
    endtask
    task t_prio;
        @(posedge sys_clk);
        f <= '1;
        for (int k = 0; k < 16; k++)
        begin
            sc[k*5+:5] <= k[4:0];
            sa[k*32+:32] <= 32'hA000 + k;
        end
        for (int k = 0; k <= 16; k++)
        begin
            @(posedge sys_clk);
            se <= 16'hFFFF << k;
            w(2);
            chk(va, k < 16 ? 32'hA000 + k : da);
        end
        @(posedge sys_clk);
        se <= '1;
        fs <= 19'h00001;
        w(2);
        chk(va, 32'h0000A001);
        chk(fst, 1);
        chk({fr, nr}, 3);
        chk(hq, 32'hFFFFFFFF);
        @(posedge sys_clk);
        fs <= '1;
        w(2);
        chk({nr, va}, {1'b0, da});
        @(posedge sys_clk);
        fs <= 19'h00001;
        en <= 19'h00004;
        w(2);
        chk(va, 32'h0000A002);
        chk(nst, 4);
        chk({fr, fst}, 0);
        chk(hq, 32'h0000A002);
        chk(rs, 19'h7FFFF);
    endtask
    initial
    begin
        w(5);
        chk({fr, nr, va}, 0);
        @(posedge sys_clk);
        rst <= 0;
        t_map;
        t_prio;
        close_out;
    end
endmodule
